// File: slc_pkg.sv
`default_nettype none
package slc_pkg;
	localparam int ADDR_W         = 8;
	localparam int DATA_W         = 32;
	localparam int CNT_W          = 16;
	localparam int IN_PTS         = 16;
	localparam int OUT_REFS       = 16;
	localparam int PHYS_OUTS      = 12;
	localparam int IRQ_W          = 4;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_OUTIMG  = 8'h04;
	localparam logic [7:0] OFF_PRELOAD = 8'h08;
	localparam logic [7:0] OFF_ACCUM   = 8'h0c;
	localparam logic [7:0] OFF_CAPTURE = 8'h10;
	localparam logic [7:0] OFF_STATUS  = 8'h14;
	localparam logic [7:0] OFF_MASK    = 8'h18;
	localparam logic [7:0] OFF_INPUTS  = 8'h1c;
	localparam logic [7:0] OFF_LEDS    = 8'h20;

	// control register fields
	localparam int CTRL_MODE_LO   = 0;
	localparam int CTRL_MODE_HI   = 1;
	localparam int CTRL_STROBE    = 2;
	localparam int CTRL_FAULT     = 3;
	localparam int CTRL_CNT_EN    = 4;
	localparam int CTRL_W         = 5;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// status / mask bits
	localparam int ST_COUNT       = 0;
	localparam int ST_MATCH       = 1;
	localparam int ST_PRELOAD     = 2;
	localparam int ST_CAPTURE     = 3;

	// led readback bits
	localparam int LD_POWER       = 0;
	localparam int LD_BATT        = 1;
	localparam int LD_OK          = 2;
	localparam int LD_RUN         = 3;
	localparam int LD_COUNT       = 4;
	localparam int LD_MATCH       = 5;
	localparam int LD_W           = 6;

	typedef enum logic [1:0] {
		MODE_STOP_IO_DIS,
		MODE_STOP_IO_EN,
		MODE_RUN,
		MODE_SPARE
	} slc_mode_t;

	// timing
	localparam int CLK_HZ         = 40_000_000;
	localparam int COUNT_MAX_HZ   = 10_000;
	localparam int LED_STRETCH_US = 20_000;
	localparam int LED_STRETCH_CYC = LED_STRETCH_US * (CLK_HZ / 1_000_000);
	localparam int STRETCH_W      = 20;
	localparam int SYNC_W         = IN_PTS + 4;
endpackage
`default_nettype wire

// File: slc_status.sv
// Overview of operation
// - power led on while supply source correct and operating, off on fault or no power
// - low battery led on while battery monitor reports voltage too low
// - each input led follows its conditioned input in every cpu mode
// - each output led lights when its commanded output reference bit is one
// - stop with outputs disabled forces every physical output off
// - stop with outputs enabled holds last or user written output values
// - run mode drives physical outputs from the program's output values
// - references 13 to 16 have no physical point, leds show coil state only
// - health led on while no fault, off once the cpu flags a problem
// - run led lit exactly while the cpu is in run mode
// - count activity led flashes on each count edge, steady at high rates
// - preload match led lit while accumulator equals preload value
// - each qualified count edge increments the 16-bit accumulator by one, unless a preload lands in the same cycle
// - in preload mode a strobe input edge loads the preload value
// - in strobe mode a strobe input edge copies accumulator into capture register
// - count rates up to 10 kHz are accepted without missed edges
`timescale 1ns/10ps
`default_nettype none
module slc_status #(
	parameter int STRETCH_CYC = slc_pkg::LED_STRETCH_CYC
) (
	input  wire logic                          CLOCK,
	input  wire logic                          RST_B,
	input  wire logic [slc_pkg::ADDR_W-1:0]    ADDR,
	input  wire logic [slc_pkg::DATA_W-1:0]    WDATA,
	input  wire logic                          WR,
	input  wire logic                          RD,
	output logic      [slc_pkg::DATA_W-1:0]    RDATA,
	input  wire logic                          PSU_GOOD,
	input  wire logic                          BATT_LOW,
	input  wire logic [slc_pkg::IN_PTS-1:0]    FIELD_IN,
	input  wire logic                          COUNT_IN,
	input  wire logic                          STROBE_IN,
	output logic      [slc_pkg::PHYS_OUTS-1:0] FIELD_OUT,
	output logic                               POWER_LED,
	output logic                               LOW_BATT_LED,
	output logic      [slc_pkg::IN_PTS-1:0]    INPUT_LED,
	output logic      [slc_pkg::OUT_REFS-1:0]  OUTPUT_LED,
	output logic                               OK_LED,
	output logic                               PROGRAM_RUNNING_LED,
	output logic                               COUNT_ACTIVITY_LED,
	output logic                               PRELOAD_MATCH_LED,
	output logic                               IRQ
);
	import slc_pkg::*;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [SYNC_W-1:0] meta_reg;
	logic [SYNC_W-1:0] sync_reg;
	logic              count_d_reg;
	logic              strobe_d_reg;

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			meta_reg     <= '0;
			sync_reg     <= '0;
			count_d_reg  <= 1'b0;
			strobe_d_reg <= 1'b0;
		end else begin
			meta_reg     <= {PSU_GOOD, BATT_LOW, COUNT_IN, STROBE_IN, FIELD_IN};
			sync_reg     <= meta_reg;
			count_d_reg  <= sync_reg[IN_PTS+1];
			strobe_d_reg <= sync_reg[IN_PTS];
		end
	end

	wire logic [IN_PTS-1:0] in_sync    = sync_reg[IN_PTS-1:0];
	wire logic              psu_sync   = sync_reg[IN_PTS+3];
	wire logic              batt_sync  = sync_reg[IN_PTS+2];
	wire logic              count_sync = sync_reg[IN_PTS+1];
	wire logic              strb_sync  = sync_reg[IN_PTS];

	////////////////////////////////////////////////////////////////////////////
	// register file
	logic [CTRL_W-1:0]   ctrl_reg;
	logic [OUT_REFS-1:0] outimg_reg;
	logic [CNT_W-1:0]    preload_reg;
	logic [IRQ_W-1:0]    mask_reg;

	wire logic wr_ctrl    = WR && hit(ADDR, OFF_CTRL);
	wire logic wr_outimg  = WR && hit(ADDR, OFF_OUTIMG);
	wire logic wr_preload = WR && hit(ADDR, OFF_PRELOAD);
	wire logic wr_mask    = WR && hit(ADDR, OFF_MASK);
	wire logic rd_status  = RD && hit(ADDR, OFF_STATUS);

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_reg    <= CTRL_RESET;
			outimg_reg  <= '0;
			preload_reg <= '0;
			mask_reg    <= '0;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= WDATA[CTRL_W-1:0];
			if (wr_outimg)
				outimg_reg <= WDATA[OUT_REFS-1:0];
			if (wr_preload)
				preload_reg <= WDATA[CNT_W-1:0];
			if (wr_mask)
				mask_reg <= WDATA[IRQ_W-1:0];
		end
	end

	wire slc_mode_t mode      = slc_mode_t'(ctrl_reg[CTRL_MODE_HI:CTRL_MODE_LO]);
	wire logic      strb_mode = ctrl_reg[CTRL_STROBE];
	wire logic      cpu_fault = ctrl_reg[CTRL_FAULT];
	wire logic      cnt_en    = ctrl_reg[CTRL_CNT_EN];

	////////////////////////////////////////////////////////////////////////////
	// pulse counter
	logic [CNT_W-1:0] accum_reg;
	logic [CNT_W-1:0] accum_next;
	logic [CNT_W-1:0] capture_reg;

	// one-clock edges; 10 kHz leaves thousands of cycles between them
	wire logic count_edge  = cnt_en && count_sync && !count_d_reg;
	wire logic strobe_edge = cnt_en && strb_sync && !strobe_d_reg;
	wire logic do_preload  = strobe_edge && !strb_mode;
	wire logic do_capture  = strobe_edge && strb_mode;
	wire logic acc_match   = (accum_reg == preload_reg);

	// a preload in the same cycle as a count edge wins
	assign accum_next = do_preload ? preload_reg :
	                    count_edge ? CNT_W'(accum_reg + 1'b1) :
	                    accum_reg;

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			accum_reg   <= '0;
			capture_reg <= '0;
		end else begin
			accum_reg <= accum_next;
			if (do_capture)
				capture_reg <= accum_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// count activity stretch
	logic [STRETCH_W-1:0] stretch_reg;
	logic [STRETCH_W-1:0] stretch_next;

	assign stretch_next = count_edge ? STRETCH_W'(STRETCH_CYC) :
	                      (stretch_reg != '0) ? STRETCH_W'(stretch_reg - 1'b1) :
	                      stretch_reg;

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B)
			stretch_reg <= '0;
		else
			stretch_reg <= stretch_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs gated by cpu mode
	logic [PHYS_OUTS-1:0] phys_next;

	always_comb begin
		case (mode)
			MODE_STOP_IO_DIS: phys_next = '0;
			MODE_STOP_IO_EN:  phys_next = outimg_reg[PHYS_OUTS-1:0];
			MODE_RUN:         phys_next = outimg_reg[PHYS_OUTS-1:0];
			default:          phys_next = '0;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			FIELD_OUT           <= '0;
			POWER_LED           <= 1'b0;
			LOW_BATT_LED        <= 1'b0;
			INPUT_LED           <= '0;
			OUTPUT_LED          <= '0;
			OK_LED              <= 1'b0;
			PROGRAM_RUNNING_LED <= 1'b0;
			COUNT_ACTIVITY_LED  <= 1'b0;
			PRELOAD_MATCH_LED   <= 1'b0;
		end else begin
			FIELD_OUT           <= phys_next;
			POWER_LED           <= psu_sync;
			LOW_BATT_LED        <= batt_sync;
			INPUT_LED           <= in_sync;
			OUTPUT_LED          <= outimg_reg;
			OK_LED              <= !cpu_fault;
			PROGRAM_RUNNING_LED <= (mode == MODE_RUN);
			COUNT_ACTIVITY_LED  <= (stretch_next != '0);
			PRELOAD_MATCH_LED   <= (accum_next == preload_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status, cleared by reading it; a new event wins over the clear
	logic              match_d_reg;
	logic [IRQ_W-1:0]  status_reg;
	logic [IRQ_W-1:0]  events;

	always_comb begin
		events              = '0;
		events[ST_COUNT]    = count_edge;
		events[ST_MATCH]    = acc_match && !match_d_reg;
		events[ST_PRELOAD]  = do_preload;
		events[ST_CAPTURE]  = do_capture;
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			// accumulator and preload both reset to zero, so they start out matched;
			// a low reset value here would post a false match event after reset
			match_d_reg <= 1'b1;
			status_reg  <= '0;
			IRQ         <= 1'b0;
		end else begin
			match_d_reg <= acc_match;
			status_reg  <= (rd_status ? '0 : status_reg) | events;
			IRQ         <= |(((rd_status ? '0 : status_reg) | events) & mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port
	logic [LD_W-1:0]   led_vec;
	logic [DATA_W-1:0] rd_mux;

	always_comb begin
		led_vec           = '0;
		led_vec[LD_POWER] = POWER_LED;
		led_vec[LD_BATT]  = LOW_BATT_LED;
		led_vec[LD_OK]    = OK_LED;
		led_vec[LD_RUN]   = PROGRAM_RUNNING_LED;
		led_vec[LD_COUNT] = COUNT_ACTIVITY_LED;
		led_vec[LD_MATCH] = PRELOAD_MATCH_LED;
	end

	always_comb begin
		rd_mux = '0;
		case (ADDR)
			OFF_CTRL:    rd_mux = DATA_W'(ctrl_reg);
			OFF_OUTIMG:  rd_mux = DATA_W'(outimg_reg);
			OFF_PRELOAD: rd_mux = DATA_W'(preload_reg);
			OFF_ACCUM:   rd_mux = DATA_W'(accum_reg);
			OFF_CAPTURE: rd_mux = DATA_W'(capture_reg);
			OFF_STATUS:  rd_mux = DATA_W'(status_reg);
			OFF_MASK:    rd_mux = DATA_W'(mask_reg);
			OFF_INPUTS:  rd_mux = DATA_W'(in_sync);
			OFF_LEDS:    rd_mux = DATA_W'(led_vec);
			default:     rd_mux = '0;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B)
			RDATA <= '0;
		else
			RDATA <= RD ? rd_mux : '0;
	end
endmodule
`default_nettype wire

// File: slc_status_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module slc_status_chk
	import slc_pkg::*;
#(
	parameter int STRETCH_CYC = LED_STRETCH_CYC
) (
	input wire logic                        CLOCK,
	input wire logic                        RST_B,
	input wire logic [slc_pkg::ADDR_W-1:0]    ADDR,
	input wire logic [slc_pkg::DATA_W-1:0]    WDATA,
	input wire logic                        WR,
	input wire logic                        PSU_GOOD,
	input wire logic                        BATT_LOW,
	input wire logic [slc_pkg::IN_PTS-1:0]    FIELD_IN,
	input wire logic                        COUNT_IN,
	input wire logic [slc_pkg::PHYS_OUTS-1:0] FIELD_OUT,
	input wire logic                        POWER_LED,
	input wire logic                        LOW_BATT_LED,
	input wire logic [slc_pkg::IN_PTS-1:0]    INPUT_LED,
	input wire logic [slc_pkg::OUT_REFS-1:0]  OUTPUT_LED,
	input wire logic                        OK_LED,
	input wire logic                        PROGRAM_RUNNING_LED,
	input wire logic                        COUNT_ACTIVITY_LED
);
	// shadow of control and output image, tracked from bus writes
	logic [4:0]  ctrl_s;
	logic [15:0] img_s;
	logic        alive;
	wire         wr_ctrl  = WR && ADDR == OFF_CTRL;
	wire         wr_img   = WR && ADDR == OFF_OUTIMG;
	wire         drive_on = ctrl_s[1:0] == MODE_STOP_IO_EN || ctrl_s[1:0] == MODE_RUN;
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_s <= '0;
			img_s <= '0;
			alive <= 1'b0;
		end else begin
			ctrl_s <= wr_ctrl ? WDATA[4:0] : ctrl_s;
			img_s <= wr_img ? WDATA[15:0] : img_s;
			alive <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	a_power_led: assert property ($stable(PSU_GOOD)[*5] |-> POWER_LED == PSU_GOOD)
		else $error("power led wrong");
	a_batt_led: assert property ($stable(BATT_LOW)[*5] |-> LOW_BATT_LED == BATT_LOW)
		else $error("battery led wrong");
	a_input_leds: assert property ($stable(FIELD_IN)[*5] |-> INPUT_LED == FIELD_IN)
		else $error("input leds wrong");
	a_outputs_off: assert property (alive && !$past(drive_on) |-> FIELD_OUT == 12'h000)
		else $error("outputs not forced off");
	a_outputs_drive: assert property (alive && $past(drive_on) |-> FIELD_OUT == $past(img_s[11:0]))
		else $error("outputs not from image");
	a_output_leds: assert property (alive |-> OUTPUT_LED == $past(img_s))
		else $error("output leds wrong");
	a_run_led: assert property (alive |-> PROGRAM_RUNNING_LED == ($past(ctrl_s[1:0]) == MODE_RUN))
		else $error("run led wrong");
	a_ok_led: assert property (alive |-> OK_LED == !$past(ctrl_s[CTRL_FAULT]))
		else $error("ok led wrong");
	a_act_rise: assert property ($rose(COUNT_IN) && ctrl_s[CTRL_CNT_EN] |-> ##[2:6] COUNT_ACTIVITY_LED)
		else $error("activity led missing");
	a_act_hold: assert property ($rose(COUNT_ACTIVITY_LED) |=> COUNT_ACTIVITY_LED[*6])
		else $error("activity led too short");
endmodule
bind slc_status slc_status_chk #(.STRETCH_CYC(STRETCH_CYC)) i_slc_status_chk (.CLOCK, .RST_B, .ADDR,
	.WDATA, .WR, .PSU_GOOD, .BATT_LOW, .FIELD_IN, .COUNT_IN, .FIELD_OUT, .POWER_LED, .LOW_BATT_LED,
	.INPUT_LED, .OUTPUT_LED, .OK_LED, .PROGRAM_RUNNING_LED, .COUNT_ACTIVITY_LED);
`default_nettype wire

// File: slc_field_model.sv
`timescale 1ns/10ps
`default_nettype none
module slc_field_model (
	input  wire logic CLOCK,
	output var logic  cnt_pin,
	output var logic  stb_pin
);
	initial begin
		cnt_pin = 1'b0;
		stb_pin = 1'b0;
	end
	// one pin pulse: three clocks high then three low, past the two clock minimum
	task automatic pulse(input bit strobe);
		for (int i = 0; i < 6; i++) begin
			@(posedge CLOCK);
			if (strobe)
				stb_pin <= i < 3;
			else
				cnt_pin <= i < 3;
		end
	endtask
endmodule
`default_nettype wire

// File: slc_status_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
	$display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module slc_status_tb_top;
	import slc_pkg::*;
	logic        CLOCK = 0, RST_B = 0, WR = 0, RD = 0, PSU_GOOD = 0, BATT_LOW = 0;
	logic [7:0]  ADDR = 0;
	logic [31:0] WDATA = 0, rv;
	logic [15:0] FIELD_IN = 0;
	wire  [31:0] RDATA;
	wire  [11:0] FIELD_OUT;
	wire  [15:0] INPUT_LED, OUTPUT_LED;
	wire         POWER_LED, LOW_BATT_LED, OK_LED, PROGRAM_RUNNING_LED, COUNT_ACTIVITY_LED;
	wire         PRELOAD_MATCH_LED, IRQ, COUNT_IN, STROBE_IN;
	int          bad_count = 0, checked = 0;
	always #12.5 CLOCK = ~CLOCK;
	slc_status #(.STRETCH_CYC(8)) i_slc_status (.CLOCK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA,
		.PSU_GOOD, .BATT_LOW, .FIELD_IN, .COUNT_IN, .STROBE_IN, .FIELD_OUT, .POWER_LED, .LOW_BATT_LED,
		.INPUT_LED, .OUTPUT_LED, .OK_LED, .PROGRAM_RUNNING_LED, .COUNT_ACTIVITY_LED, .PRELOAD_MATCH_LED, .IRQ);
	slc_field_model i_slc_field_model (.CLOCK, .cnt_pin(COUNT_IN), .stb_pin(STROBE_IN));
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge CLOCK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLOCK);
		RD <= 1'b0;
		@(negedge CLOCK);
		rv = RDATA;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge CLOCK);
	endtask
	task automatic pls(input bit s);
		i_slc_field_model.pulse(s);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_pins;
		for (int m = 0; m < 3; m++) begin
			wr(OFF_CTRL, m);
			PSU_GOOD <= m[0];
			BATT_LOW <= ~m[0];
			FIELD_IN <= 16'h1234 << m;
			tick(5);
			`CHK(POWER_LED, m[0])
			`CHK(LOW_BATT_LED, ~m[0])
			`CHK(INPUT_LED, 16'h1234 << m)
		end
	endtask
	task automatic t_outputs;
		wr(OFF_OUTIMG, 32'h0000_f5a3);
		for (int m = 0; m < 4; m++) begin
			wr(OFF_CTRL, m);
			tick(3);
			`CHK(FIELD_OUT, (m == 1 || m == 2) ? 12'h5a3 : 12'h000)
			`CHK(OUTPUT_LED, 16'hf5a3)
			`CHK(PROGRAM_RUNNING_LED, m == 2)
		end
		wr(OFF_CTRL, 32'h0000_000a);
		wr(OFF_OUTIMG, 32'h0000_0a5c);
		tick(3);
		`CHK(FIELD_OUT, 12'ha5c)
		`CHK(OK_LED, 1'b0)
		wr(OFF_CTRL, 32'h0000_0002);
		tick(3);
		`CHK(OK_LED, 1'b1)
	endtask
	task automatic t_count;
		pls(0);
		rd(OFF_ACCUM);
		`CHK(rv, 32'h0)
		wr(OFF_MASK, 32'h0000_0001);
		wr(OFF_CTRL, 32'h0000_0012);
		rd(OFF_STATUS);
		repeat (5) pls(0);
		tick(2);
		`CHK(COUNT_ACTIVITY_LED, 1'b1)
		`CHK(IRQ, 1'b1)
		rd(OFF_ACCUM);
		`CHK(rv, 32'h5)
		rd(OFF_STATUS);
		`CHK(rv[0], 1'b1)
		tick(12);
		`CHK(IRQ, 1'b0)
		`CHK(COUNT_ACTIVITY_LED, 1'b0)
		wr(OFF_MASK, 32'h0);
		pls(0);
		tick(2);
		`CHK(IRQ, 1'b0)
	endtask
	task automatic t_preload;
		wr(OFF_PRELOAD, 32'h0000_fffe);
		pls(1);
		rd(OFF_ACCUM);
		`CHK(rv, 32'h0000_fffe)
		`CHK(PRELOAD_MATCH_LED, 1'b1)
		pls(0);
		tick(2);
		`CHK(PRELOAD_MATCH_LED, 1'b0)
		pls(0);
		pls(0);
		wr(OFF_CTRL, 32'h0000_0016);
		pls(1);
		pls(0);
		rd(OFF_CAPTURE);
		`CHK(rv, 32'h1)
		rd(OFF_ACCUM);
		`CHK(rv, 32'h2)
	endtask
	////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge CLOCK);
		RST_B <= 1'b1;
		rd(OFF_CTRL);
		`CHK(rv, 32'h0)
		rd(8'h40);
		`CHK(rv, 32'h0)
		rd(OFF_STATUS);
		`CHK(rv, 32'h0)
		t_pins;
		t_outputs;
		t_count;
		t_preload;
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge CLOCK);
		bad_count++;
		complete_run;
	end
endmodule
`undef CHK
`default_nettype wire
